// ==== rtl/flash_status.sv ====
`timescale 1ns/1ns
// How it works
// [R1] Erase toggle bit flips per read only in sectors selected for erase.
// [R2] Erase toggle status is valid from the last write strobe onward.
// [R3] Host double-reads status and compares toggle bit to detect completion.
// [R4] Host checks timeout flag, rechecks toggle, then resets on failure.
// [R5] Host returning from other work restarts the double-read check.
// [R6] Active erase: selected-sector reads flip progress and erase toggles.
// [R7] Erase suspend: selected sector shows erase toggle only; others array data.
// [R8] Program in suspend: progress toggle flips anywhere; erase toggle meaningless.
// [R9] Timeout flag sets when an operation hits its pulse-count limit.
// [R10] Programming a 1 over a 0 halts and ends in timeout.
// [R11] Reset after timeout returns to read or suspend-read mode.
// [R12] Erase timer flag reads 0 in window, 1 once erase begins.
// [R13] Each added sector erase restarts the window; chip erase skips it.
// [R14] Erase running: every command except suspend is ignored.
// [R15] Host skips timer checks only with commands under 50 us apart.
// [R16] Ready/busy pulls low while busy, floats when ready or suspended.
// [R17] While busy, program and erase commands are refused except suspend.
// [R18] Busy follows the fourth strobe for program, sixth for erase.
// [R19] Hardware reset during an operation keeps busy until internal reset ends.
// [R20] Poll and erase toggle are valid only at program or selected addresses.
// [R21] Reset ignores address and aborts unstarted sequences to read mode.
// [R22] Reset is ignored once an embedded operation has started.
// [R23] Reset aborts identification entry and leaves identification mode.
// [R24] Reset before an operation returns within 250 ns.
// [R25] Progress toggle flips per read while busy, stops on completion.
// [R26] Poll bit shows complement while programming, 0 erasing, 1 after.
module flash_status #(
  parameter int WORDS        = 16,
  parameter int SECTORS      = 4,
  parameter int PROG_PULSES  = 8,
  parameter int ERASE_PULSES = 16,
  parameter int MAX_PULSES   = 48
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        hwrst_n_i,
  input  wire logic        ready_busy_i,
  output logic             ready_busy_o,
  output logic             ready_busy_oe_o
);

  localparam int AW = $clog2(WORDS);
  localparam int SW = $clog2(SECTORS);
  localparam int PMAX = (MAX_PULSES > ERASE_PULSES) ? MAX_PULSES : ERASE_PULSES;
  localparam int PW = $clog2(PMAX + 1);

  // Refuse shapes the decode cannot serve
  if (WORDS < 2 || (1 << AW) != WORDS || (1 << SW) != SECTORS || SECTORS > 16 ||
      SECTORS > WORDS || PROG_PULSES < 1 || ERASE_PULSES < 1 ||
      MAX_PULSES <= PROG_PULSES) begin : g_bad
    $error("flash_status: unsupported parameters");
  end

  typedef struct packed {
    flash_status_pkg::mode_t  mode;
    logic [2:0]               step;
    logic                     kprog;
    logic                     rsusp;
    logic [11:0]              cnt;
    logic [PW-1:0]            pulses;
    logic [SECTORS-1:0]       sel;
    logic                     tog6;
    logic                     tog2;
    logic                     fail;
    logic [AW-1:0]            addr;
    logic [AW-1:0]            paddr;
    logic [7:0]               pdata;
    logic [31:0]              rdata;
    logic                     ack;
    logic [WORDS-1:0][7:0]    mem;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  // Sector index of a word address
  function automatic logic [SW-1:0] sector_of(input logic [AW-1:0] a);
    sector_of = SW'(a >> (AW - SW));
  endfunction

  // Modes that hold the ready/busy pin low
  function automatic logic busy_of(input flash_status_pkg::mode_t m);
    busy_of = (m == flash_status_pkg::M_PROG) || (m == flash_status_pkg::M_ESPROG) ||
              (m == flash_status_pkg::M_ERTMO) || (m == flash_status_pkg::M_ERASING) ||
              (m == flash_status_pkg::M_RSTWAIT) || (m == flash_status_pkg::M_HWRST);
  endfunction

  // Byte seen by a read of the array window
  function automatic logic [7:0] flash_rd(input state_t s, input logic [AW-1:0] a);
    flash_status_pkg::status_byte_t b;
    b = '0;
    flash_rd = s.mem[a];
    unique case (s.mode)
      flash_status_pkg::M_PROG, flash_status_pkg::M_ESPROG: begin
        b.poll = ~s.pdata[7];                                       // R26
        b.tog6 = s.tog6;                                            // R8
        b.fail = s.fail;
        b.tog2 = s.tog2;
        flash_rd = b;
      end
      flash_status_pkg::M_ERTMO, flash_status_pkg::M_ERASING: begin
        b.tog6  = s.tog6;                                           // R6
        b.fail  = s.fail;
        b.timer = (s.mode == flash_status_pkg::M_ERASING);          // R12
        b.tog2  = s.tog2;                                           // R20
        flash_rd = b;
      end
      flash_status_pkg::M_ESUSP: begin
        if (s.sel[sector_of(a)]) begin
          b.poll = 1'b1;
          b.tog6 = s.tog6;                                          // R7
          b.tog2 = s.tog2;
          flash_rd = b;
        end
      end
      flash_status_pkg::M_AUTOSEL: flash_rd = flash_status_pkg::AUTOSEL_ID;
      default: flash_rd = s.mem[a];
    endcase
  endfunction

  logic       req;
  logic       fire;
  logic       rd_fire;
  logic       cmd_fire;
  logic [3:0] code;
  logic [7:0] cdata;

  // Bus decode: effects land on the edge where ack is sampled
  always_comb begin
    req      = cyc_i & stb_i;
    fire     = req & state_ff.ack;
    rd_fire  = fire & ~we_i & (adr_i == flash_status_pkg::READ_OFS);
    cmd_fire = fire & we_i & sel_i[0] & sel_i[1] & (adr_i == flash_status_pkg::CMD_OFS);
    code     = dat_i[flash_status_pkg::CMD_CODE_LSB +: 4];
    cdata    = dat_i[flash_status_pkg::CMD_DATA_LSB +: 8];
  end

  // Next state of the whole block
  always_comb begin
    logic [2:0] st;
    logic       ok;
    logic       ctx;
    logic       done;
    nxt_state = state_ff;
    st        = '0;
    ok        = 1'b0;
    ctx       = 1'b0;
    done      = 1'b0;

    // Embedded progress
    unique case (state_ff.mode)
      flash_status_pkg::M_ERTMO: begin
        if (state_ff.cnt == '0) begin
          nxt_state.mode   = flash_status_pkg::M_ERASING;           // R12
          nxt_state.pulses = '0;
        end else begin
          nxt_state.cnt = state_ff.cnt - 12'h001;
        end
      end
      flash_status_pkg::M_ERASING: begin
        if (state_ff.pulses == PW'(ERASE_PULSES - 1)) begin
          for (int i = 0; i < WORDS; i++) begin
            if (state_ff.sel[sector_of(AW'(i))]) begin
              nxt_state.mem[i] = flash_status_pkg::ERASED;
            end
          end
          nxt_state.sel  = '0;
          nxt_state.mode = flash_status_pkg::M_READ;                // R25
        end else begin
          nxt_state.pulses = state_ff.pulses + PW'(1);
        end
      end
      flash_status_pkg::M_PROG, flash_status_pkg::M_ESPROG: begin
        done = (state_ff.pulses >= PW'(PROG_PULSES - 1)) &&
               ((state_ff.pdata & ~state_ff.mem[state_ff.paddr]) == 8'h00);  // R10
        if (!state_ff.fail) begin
          if (done) begin
            nxt_state.mem[state_ff.paddr] = state_ff.mem[state_ff.paddr] & state_ff.pdata;
            nxt_state.mode = (state_ff.mode == flash_status_pkg::M_ESPROG) ?
                             flash_status_pkg::M_ESUSP : flash_status_pkg::M_READ;
          end else if (state_ff.pulses == PW'(MAX_PULSES - 1)) begin
            nxt_state.fail = 1'b1;                                  // R9
          end else begin
            nxt_state.pulses = state_ff.pulses + PW'(1);
          end
        end
      end
      flash_status_pkg::M_RSTWAIT: begin
        if (state_ff.cnt == '0) begin
          nxt_state.mode = state_ff.rsusp ? flash_status_pkg::M_ESUSP :
                                            flash_status_pkg::M_READ;  // R11
          nxt_state.fail = 1'b0;
          if (!state_ff.rsusp) begin
            nxt_state.sel = '0;
          end
        end else begin
          nxt_state.cnt = state_ff.cnt - 12'h001;
        end
      end
      flash_status_pkg::M_HWRST: begin
        if (state_ff.cnt != '0) begin
          nxt_state.cnt = state_ff.cnt - 12'h001;
        end else if (hwrst_n_i) begin
          nxt_state.mode = flash_status_pkg::M_READ;
        end
      end
      default: ;
    endcase

    // Bus slave: ack one cycle after request, dropped the cycle after
    nxt_state.ack = req & ~state_ff.ack;
    if (req & ~state_ff.ack) begin
      nxt_state.rdata = '0;
      if (!we_i) begin
        unique case (adr_i)
          flash_status_pkg::ADDR_OFS: nxt_state.rdata = 32'(state_ff.addr);
          flash_status_pkg::READ_OFS: nxt_state.rdata = 32'(flash_rd(state_ff, state_ff.addr));
          flash_status_pkg::STATE_OFS: begin
            nxt_state.rdata[flash_status_pkg::ST_MODE_LSB +: 4] = state_ff.mode;
            nxt_state.rdata[flash_status_pkg::ST_BUSY]          = busy_of(state_ff.mode);
            nxt_state.rdata[flash_status_pkg::ST_FAIL]          = state_ff.fail;
            nxt_state.rdata[flash_status_pkg::ST_PIN]           = ready_busy_i;
            nxt_state.rdata[flash_status_pkg::ST_STEP_LSB +: 3] = state_ff.step;
            nxt_state.rdata[flash_status_pkg::ST_SEL_LSB +: SECTORS] = state_ff.sel;
          end
          default: nxt_state.rdata = '0;
        endcase
      end
    end
    if (fire & we_i & sel_i[0] & (adr_i == flash_status_pkg::ADDR_OFS)) begin
      nxt_state.addr = dat_i[AW-1:0];
    end

    // Read side effects on the toggle bits
    if (rd_fire) begin
      if (state_ff.mode inside {flash_status_pkg::M_PROG, flash_status_pkg::M_ESPROG,
                                flash_status_pkg::M_ERTMO, flash_status_pkg::M_ERASING}) begin
        nxt_state.tog6 = ~state_ff.tog6;                            // R25
      end
      if ((state_ff.mode inside {flash_status_pkg::M_ERTMO, flash_status_pkg::M_ERASING,
                                 flash_status_pkg::M_ESUSP}) &&
          state_ff.sel[sector_of(state_ff.addr)]) begin
        nxt_state.tog2 = ~state_ff.tog2;                            // R1
      end
    end

    // Write strobes
    if (cmd_fire) begin
      unique case (state_ff.mode)
        flash_status_pkg::M_READ, flash_status_pkg::M_ESUSP,
        flash_status_pkg::M_STEP, flash_status_pkg::M_AUTOSEL: begin
          ctx = (state_ff.mode == flash_status_pkg::M_ESUSP) ||
                ((state_ff.mode == flash_status_pkg::M_STEP) && state_ff.rsusp);
          st  = (state_ff.mode == flash_status_pkg::M_STEP) ? state_ff.step : 3'h0;
          if (code == flash_status_pkg::C_RESET) begin
            if (state_ff.mode inside {flash_status_pkg::M_STEP, flash_status_pkg::M_AUTOSEL}) begin
              nxt_state.mode = flash_status_pkg::M_RSTWAIT;         // R21
              nxt_state.cnt  = 12'(flash_status_pkg::RR_CYC - 1);   // R24
              nxt_state.step = '0;
            end
          end else if ((state_ff.mode == flash_status_pkg::M_ESUSP) &&
                       (code == flash_status_pkg::C_RESUME)) begin
            nxt_state.mode = flash_status_pkg::M_ERASING;
            // Restart erase pulses: a suspend-time program reuses the counter
            nxt_state.pulses = '0;
          end else if (state_ff.mode != flash_status_pkg::M_AUTOSEL) begin  // R23
            unique case (st)
              3'h0, 3'h1: ok = (code == flash_status_pkg::C_UNLOCK);
              flash_status_pkg::STEP_SETUP:
                ok = (code == flash_status_pkg::C_PSETUP) ||
                     (!ctx && (code == flash_status_pkg::C_ESETUP)) ||
                     (!ctx && (code == flash_status_pkg::C_ASETUP));
              flash_status_pkg::STEP_PDATA:
                ok = state_ff.kprog ? (code == flash_status_pkg::C_PDATA) :
                                      (code == flash_status_pkg::C_UNLOCK);
              3'h4: ok = (code == flash_status_pkg::C_UNLOCK);
              flash_status_pkg::STEP_ELAST:
                ok = (code == flash_status_pkg::C_CHIP) || (code == flash_status_pkg::C_SECTOR);
              default: ok = 1'b0;
            endcase
            nxt_state.rsusp = ctx;
            nxt_state.step  = '0;
            if (!ok) begin
              nxt_state.mode = ctx ? flash_status_pkg::M_ESUSP : flash_status_pkg::M_READ;
            end else if ((st == flash_status_pkg::STEP_PDATA) && state_ff.kprog) begin
              nxt_state.mode   = ctx ? flash_status_pkg::M_ESPROG :
                                       flash_status_pkg::M_PROG;    // R18
              nxt_state.paddr  = state_ff.addr;
              nxt_state.pdata  = cdata;
              nxt_state.pulses = '0;
              nxt_state.fail   = 1'b0;
            end else if (st == flash_status_pkg::STEP_ELAST) begin
              nxt_state.pulses = '0;
              nxt_state.fail   = 1'b0;
              if (code == flash_status_pkg::C_CHIP) begin
                nxt_state.sel  = '1;
                nxt_state.mode = flash_status_pkg::M_ERASING;       // R13
              end else begin
                nxt_state.sel = SECTORS'(1) << sector_of(state_ff.addr);
                nxt_state.mode = flash_status_pkg::M_ERTMO;         // R18
                nxt_state.cnt  = 12'(flash_status_pkg::ETMO_CYC - 1);  // R2
              end
            end else if ((st == flash_status_pkg::STEP_SETUP) &&
                         (code == flash_status_pkg::C_ASETUP)) begin
              nxt_state.mode = flash_status_pkg::M_AUTOSEL;
            end else begin
              nxt_state.mode  = flash_status_pkg::M_STEP;
              nxt_state.step  = st + 3'h1;
              nxt_state.kprog = (st == flash_status_pkg::STEP_SETUP) ?
                                (code == flash_status_pkg::C_PSETUP) : state_ff.kprog;
            end
          end
        end
        flash_status_pkg::M_ERTMO: begin
          if (code == flash_status_pkg::C_SECTOR) begin
            nxt_state.sel = state_ff.sel | (SECTORS'(1) << sector_of(state_ff.addr));
            nxt_state.cnt = 12'(flash_status_pkg::ETMO_CYC - 1);    // R13
          end else if (code == flash_status_pkg::C_SUSPEND) begin
            nxt_state.mode = flash_status_pkg::M_ESUSP;
          end
        end
        flash_status_pkg::M_ERASING, flash_status_pkg::M_PROG, flash_status_pkg::M_ESPROG: begin
          if ((code == flash_status_pkg::C_SUSPEND) &&  // R17
              (state_ff.mode == flash_status_pkg::M_ERASING)) begin
            nxt_state.mode = flash_status_pkg::M_ESUSP;             // R14
          end else if ((code == flash_status_pkg::C_RESET) && state_ff.fail) begin
            nxt_state.mode = flash_status_pkg::M_RSTWAIT;           // R11
            nxt_state.cnt  = 12'(flash_status_pkg::RR_CYC - 1);
          end
        end
        default: ;                                                  // R22
      endcase
    end

    // Hardware reset overrides everything
    if (!hwrst_n_i) begin
      nxt_state.step = '0;
      if (busy_of(state_ff.mode) && (state_ff.mode != flash_status_pkg::M_RSTWAIT)) begin
        if (state_ff.mode != flash_status_pkg::M_HWRST) begin
          nxt_state.mode = flash_status_pkg::M_HWRST;               // R19
          nxt_state.cnt  = 12'(flash_status_pkg::READY_CYC - 1);
        end
      end else begin
        nxt_state.mode = flash_status_pkg::M_READ;
      end
      nxt_state.sel   = '0;
      nxt_state.fail  = 1'b0;
      nxt_state.rsusp = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff     <= '0;
      state_ff.mem <= '1;
    end else if (ce_i) begin
      state_ff <= nxt_state;
    end
  end

  // Outputs: open-drain pin pulls low while busy
  assign dat_o           = state_ff.rdata;
  assign ack_o           = state_ff.ack;
  assign ready_busy_o    = 1'b0;
  assign ready_busy_oe_o = busy_of(state_ff.mode);                  // R16

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_prog_busy;
    ce_i && cmd_fire && hwrst_n_i && (state_ff.mode == flash_status_pkg::M_STEP) &&
    (state_ff.step == flash_status_pkg::STEP_PDATA) && state_ff.kprog &&
    (code == flash_status_pkg::C_PDATA) |=> ready_busy_oe_o;
  endproperty
  a_prog_busy: assert property (p_prog_busy) else $error("no busy after program strobe"); // R18

  property p_susp_float;
    (state_ff.mode == flash_status_pkg::M_ESUSP) |-> !ready_busy_oe_o;
  endproperty
  a_susp_float: assert property (p_susp_float) else $error("busy while suspended"); // R16

  property p_rst_ignored;
    ce_i && cmd_fire && hwrst_n_i && (code == flash_status_pkg::C_RESET) && !state_ff.fail &&
    (state_ff.mode == flash_status_pkg::M_ERASING) && (state_ff.pulses < PW'(ERASE_PULSES - 1))
    |=> (state_ff.mode == flash_status_pkg::M_ERASING);
  endproperty
  a_rst_ignored: assert property (p_rst_ignored) else $error("reset stopped erase"); // R22

  // Recovery age in enabled cycles, kept apart from the recovery counter
  logic [11:0] rr_age_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rr_age_ff <= 12'h000;
    end else if (ce_i) begin
      rr_age_ff <= (state_ff.mode == flash_status_pkg::M_RSTWAIT) ?
                   rr_age_ff + 12'h001 : 12'h000;
    end
  end

  property p_rst_time;
    (state_ff.mode == flash_status_pkg::M_RSTWAIT) |->
    (rr_age_ff < 12'(flash_status_pkg::RR_CYC));
  endproperty
  a_rst_time: assert property (p_rst_time) else $error("reset recovery too slow"); // R24

  property p_tog6;
    ce_i && rd_fire && (state_ff.mode == flash_status_pkg::M_PROG) |=>
    (state_ff.tog6 != $past(state_ff.tog6));
  endproperty
  a_tog6: assert property (p_tog6) else $error("progress toggle stuck"); // R25

  property p_tog2_unsel;
    ce_i && rd_fire && (state_ff.mode == flash_status_pkg::M_ERASING) &&
    !state_ff.sel[sector_of(state_ff.addr)] |=> $stable(state_ff.tog2);
  endproperty
  a_tog2_unsel: assert property (p_tog2_unsel) else $error("erase toggle off-sector"); // R1

  property p_timer;
    ce_i && hwrst_n_i && (state_ff.mode == flash_status_pkg::M_ERTMO) &&
    (state_ff.cnt == '0) && !cmd_fire
    |=> (state_ff.mode == flash_status_pkg::M_ERASING);
  endproperty
  a_timer: assert property (p_timer) else $error("erase did not begin after window"); // R12

  property p_hwrst_busy;
    ce_i && !hwrst_n_i && (state_ff.mode == flash_status_pkg::M_PROG) |=> ready_busy_oe_o [*8];
  endproperty
  a_hwrst_busy: assert property (p_hwrst_busy) else $error("busy dropped in reset"); // R19

  property p_fail_set;
    ce_i && hwrst_n_i && !cmd_fire && (state_ff.mode == flash_status_pkg::M_PROG) &&
    !state_ff.fail && (state_ff.pulses == PW'(MAX_PULSES - 1)) &&
    ((state_ff.pdata & ~state_ff.mem[state_ff.paddr]) != 8'h00)
    |=> state_ff.fail && ready_busy_oe_o;
  endproperty
  a_fail_set: assert property (p_fail_set) else $error("timeout flag not raised"); // R9

  c_prog_done: cover property ((state_ff.mode == flash_status_pkg::M_PROG) ##1
                               (state_ff.mode == flash_status_pkg::M_READ));
  c_erase_run: cover property (state_ff.mode == flash_status_pkg::M_ERASING);
  c_suspend:   cover property (state_ff.mode == flash_status_pkg::M_ESPROG);
  c_fail:      cover property (state_ff.fail);

endmodule

// ==== inc/flash_status_pkg.sv ====
package flash_status_pkg;

  // Clock rate and derived period
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;

  // Reset command recovery, a longest time: rounds down
  localparam int RR_NS  = 250;
  localparam int RR_CYC = (RR_NS / CLK_NS < 1) ? 1 : RR_NS / CLK_NS;

  // Sector erase window, a least time: rounds up
  localparam int ETMO_US  = 50;
  localparam int ETMO_CYC = (ETMO_US * 1000 + CLK_NS - 1) / CLK_NS;

  // Internal reset time after a hardware reset during an operation
  localparam int READY_NS  = 20_000;
  localparam int READY_CYC = (READY_NS + CLK_NS - 1) / CLK_NS;

  // Register byte offsets
  localparam logic [7:0] CMD_OFS   = 8'h00;
  localparam logic [7:0] ADDR_OFS  = 8'h04;
  localparam logic [7:0] READ_OFS  = 8'h08;
  localparam logic [7:0] STATE_OFS = 8'h0C;

  // Command register fields
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_DATA_LSB = 8;

  // State register fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_BUSY     = 4;
  localparam int ST_FAIL     = 5;
  localparam int ST_PIN      = 6;
  localparam int ST_STEP_LSB = 8;
  localparam int ST_SEL_LSB  = 16;

  // Write strobe codes
  localparam logic [3:0] C_RESET   = 4'h0;
  localparam logic [3:0] C_UNLOCK  = 4'h1;
  localparam logic [3:0] C_PSETUP  = 4'h2;
  localparam logic [3:0] C_ESETUP  = 4'h3;
  localparam logic [3:0] C_CHIP    = 4'h4;
  localparam logic [3:0] C_SECTOR  = 4'h5;
  localparam logic [3:0] C_PDATA   = 4'h6;
  localparam logic [3:0] C_SUSPEND = 4'h7;
  localparam logic [3:0] C_RESUME  = 4'h8;
  localparam logic [3:0] C_ASETUP  = 4'h9;

  // Sequence positions (strobe number minus one)
  localparam logic [2:0] STEP_SETUP = 3'h2;
  localparam logic [2:0] STEP_PDATA = 3'h3;
  localparam logic [2:0] STEP_ELAST = 3'h5;

  // Identification byte, value arbitrary
  localparam logic [7:0] AUTOSEL_ID = 8'h5A;
  localparam logic [7:0] ERASED     = 8'hFF;

  typedef enum logic [3:0] {
    M_READ    = 4'h0, M_STEP    = 4'h1, M_ERTMO   = 4'h3, M_ERASING = 4'h2,
    M_ESUSP   = 4'h6, M_ESPROG  = 4'h7, M_PROG    = 4'h5, M_AUTOSEL = 4'h4,
    M_RSTWAIT = 4'hC, M_HWRST   = 4'hD
  } mode_t;

  typedef struct packed {
    logic       poll;
    logic       tog6;
    logic       fail;
    logic       rsvd4;
    logic       timer;
    logic       tog2;
    logic [1:0] rsvd;
  } status_byte_t;

endpackage

// ==== tb/rb_pullup.sv ====
`timescale 1ns/1ns
module rb_pullup (
  input  wire logic oe_i,
  input  wire logic drv_i,
  output logic      level_o
);
  // Open-drain wire with pull-up: floats high when released
  assign level_o = oe_i ? drv_i : 1'b1;
endmodule

// ==== tb/flash_write_status_and_reset_cmd_test.sv ====
`timescale 1ns/1ns
module flash_write_status_and_reset_cmd_test;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ce = 1, hwrst_n = 1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, dat_o, q, r1, r2;
  logic ack_o, rb_o, rb_oe, rb_lvl;
  int error_cnt = 0, comparisons = 0, i;
  logic [7:0] tadr [4] = '{flash_status_pkg::STATE_OFS, 8'h10, flash_status_pkg::READ_OFS,
                          flash_status_pkg::ADDR_OFS};
  logic [31:0] texp [4] = '{32'h40, 32'h0, 32'hFF, 32'h0};
  always #10 clk_i = ~clk_i;
  flash_status #(.PROG_PULSES(16), .ERASE_PULSES(64), .MAX_PULSES(24)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .dat_i(dat), .sel_i(4'hF), .dat_o(dat_o), .ack_o(ack_o),
    .hwrst_n_i(hwrst_n), .ready_busy_i(rb_lvl), .ready_busy_o(rb_o), .ready_busy_oe_o(rb_oe));
  rb_pullup far (.oe_i(rb_oe), .drv_i(rb_o), .level_o(rb_lvl));
  // Verdict and end of run
  task report_and_stop;
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One classic Wishbone cycle, held until ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    cyc <= 0; stb <= 0;
    if (n >= 50) begin error_cnt++; report_and_stop; end
  endtask
  task cmd(input logic [3:0] c, input logic [7:0] v);
    wb(1, flash_status_pkg::CMD_OFS, {16'h0, v, 4'h0, c}, q);
  endtask
  task wait_idle;
    int n;
    n = 0;
    @(posedge clk_i);
    while (rb_oe !== 1'b0 && n < 5000) begin @(posedge clk_i); n++; end
    if (n >= 5000) begin error_cnt++; report_and_stop; end
  endtask
  task prog(input logic [3:0] a, input logic [7:0] v);
    wb(1, flash_status_pkg::ADDR_OFS, {28'h0, a}, q);
    cmd(4'h1, 8'h00); cmd(4'h1, 8'h00); cmd(4'h2, 8'h00); cmd(4'h6, v);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    // Register table rows after reset
    for (i = 0; i < 4; i++) begin
      wb(0, tadr[i], 32'h0, q);
      chk("reg_row", texp[i], q);
    end
    chk("rb_drive", 32'h0, {31'h0, rb_o});
    // Program 0x00: busy after fourth strobe, toggle and poll status
    prog(4'h3, 8'h00);
    @(posedge clk_i);
    chk("busy_pin", 32'h0, {31'h0, rb_lvl});
    wb(0, flash_status_pkg::READ_OFS, 32'h0, r1);
    wb(0, flash_status_pkg::READ_OFS, 32'h0, r2);
    chk("prog_toggle", 32'h1, {31'h0, r1[6] ^ r2[6]});
    chk("prog_poll", 32'h1, {31'h0, r1[7]});
    wait_idle;
    wb(0, flash_status_pkg::READ_OFS, 32'h0, q);
    chk("prog_data", 32'h0, q);
    // One over zero halts and raises the timeout flag
    prog(4'h3, 8'hFF);
    repeat (40) @(posedge clk_i);
    wb(0, flash_status_pkg::READ_OFS, 32'h0, q);
    chk("fail_flag", 32'h1, {31'h0, q[5]});
    wb(0, flash_status_pkg::READ_OFS, 32'h0, r2);
    chk("fail_retoggle", 32'h1, {31'h0, q[6] ^ r2[6]});
    cmd(4'h0, 8'h00);
    wait_idle;
    wb(0, flash_status_pkg::STATE_OFS, 32'h0, q);
    chk("after_reset", 32'h40, {25'h0, q[6:0]});
    // Reset aborts a half-written sequence
    cmd(4'h1, 8'h00); cmd(4'h1, 8'h00); cmd(4'h0, 8'h00);
    wait_idle;
    wb(0, flash_status_pkg::STATE_OFS, 32'h0, q);
    chk("abort", 32'h40, {25'h0, q[6:0]});
    // Sector erase: timer flag 0 in window, then 1 and toggling
    wb(1, flash_status_pkg::ADDR_OFS, 32'h0, q);
    cmd(4'h1, 8'h00); cmd(4'h1, 8'h00); cmd(4'h3, 8'h00);
    cmd(4'h1, 8'h00); cmd(4'h1, 8'h00); cmd(4'h5, 8'h00);
    wb(0, flash_status_pkg::READ_OFS, 32'h0, q);
    chk("timer_open", 32'h0, {30'h0, q[7], q[3]});
    repeat (2500) @(posedge clk_i);
    wb(0, flash_status_pkg::READ_OFS, 32'h0, r1);
    wb(0, flash_status_pkg::READ_OFS, 32'h0, r2);
    chk("timer_run", 32'h1, {31'h0, r2[3]});
    chk("erase_toggles", 32'h3, {30'h0, r1[6] ^ r2[6], r1[2] ^ r2[2]});
    cmd(4'h0, 8'h00);
    @(posedge clk_i);
    chk("rst_ignored", 32'h0, {31'h0, rb_lvl});
    wait_idle;
    wb(0, flash_status_pkg::READ_OFS, 32'h0, q);
    chk("erased", 32'hFF, q);
    // Suspend in the window, program elsewhere, then resume
    cmd(4'h1, 8'h00); cmd(4'h1, 8'h00); cmd(4'h3, 8'h00);
    cmd(4'h1, 8'h00); cmd(4'h1, 8'h00); cmd(4'h5, 8'h00); cmd(4'h7, 8'h00);
    @(posedge clk_i);
    chk("susp_float", 32'h1, {31'h0, rb_lvl});
    wb(0, flash_status_pkg::READ_OFS, 32'h0, r1);
    wb(0, flash_status_pkg::READ_OFS, 32'h0, r2);
    chk("susp_toggles", 32'h1, {30'h0, r1[6] ^ r2[6], r1[2] ^ r2[2]});
    prog(4'h8, 8'h00);
    wb(0, flash_status_pkg::READ_OFS, 32'h0, r1);
    wb(0, flash_status_pkg::READ_OFS, 32'h0, r2);
    chk("susp_prog_toggle", 32'h1, {31'h0, r1[6] ^ r2[6]});
    wait_idle;
    cmd(4'h8, 8'h00);
    wb(0, flash_status_pkg::READ_OFS, 32'h0, q);
    chk("resumed_timer", 32'h1, {31'h0, q[3]});
    wait_idle;
    wb(0, flash_status_pkg::READ_OFS, 32'h0, q);
    chk("susp_prog_data", 32'h0, q);
    // Hardware reset mid-program holds busy through internal reset
    prog(4'h1, 8'h00);
    hwrst_n <= 0;
    repeat (20) @(posedge clk_i);
    hwrst_n <= 1;
    chk("hwrst_busy", 32'h0, {31'h0, rb_lvl});
    wait_idle;
    wb(0, flash_status_pkg::STATE_OFS, 32'h0, q);
    chk("hwrst_done", 32'h40, {25'h0, q[6:0]});
    // Clock enable low freezes a running program
    prog(4'h2, 8'h00);
    ce <= 0;
    repeat (40) @(posedge clk_i);
    chk("ce_freeze", 32'h0, {31'h0, rb_lvl});
    ce <= 1;
    wait_idle;
    report_and_stop;
  end
endmodule
